// *** src/fbm_defs.svh ***
`ifndef FBM_DEFS_SVH
`define FBM_DEFS_SVH

// Bus geometry
`define FBM_ADDR_W 22
`define FBM_DATA_W 16
`define FBM_BANK_W 2
`define FBM_BANK_LSB 20
`define FBM_SECT_LSB 12
// Timing in ns
`define FBM_CLK_NS 25
`define FBM_ACCESS_NS 70
`define FBM_WRITE_PULSE_NS 35
`define FBM_RESET_PULSE_NS 500
`define FBM_RESET_RECOVERY_NS 50
`define FBM_READY_BUSY_NS 20000
`define FBM_SLEEP_EXTRA_NS 30
// Cycle counts: minima round up
`define FBM_CYC_UP(ns) (((ns) + `FBM_CLK_NS - 1) / `FBM_CLK_NS)
`define FBM_ACCESS_CYC `FBM_CYC_UP(`FBM_ACCESS_NS)
`define FBM_WRITE_CYC `FBM_CYC_UP(`FBM_WRITE_PULSE_NS)
`define FBM_RESET_CYC `FBM_CYC_UP(`FBM_RESET_PULSE_NS)
`define FBM_RECOVERY_CYC `FBM_CYC_UP(`FBM_RESET_RECOVERY_NS)
`define FBM_READY_CYC `FBM_CYC_UP(`FBM_READY_BUSY_NS)
`define FBM_CNT_W 10
// Standard unlock addresses and data
`define FBM_UNLOCK_A1 22'h000555
`define FBM_UNLOCK_A2 22'h0002AA
`define FBM_UNLOCK_D1 16'h00AA
`define FBM_UNLOCK_D2 16'h0055
`define FBM_CMD_PROG 16'h00A0
`define FBM_CMD_ID 16'h0090
`define FBM_CMD_ERASE 16'h0080
`define FBM_CMD_CHIP 16'h0010
`define FBM_CMD_SECT 16'h0030
`define FBM_CMD_SUSPEND 16'h00B0
`define FBM_CMD_RESUME 16'h0030
`define FBM_CMD_EXIT 16'h00F0
`define FBM_CMD_BYPASS 16'h0020
`define FBM_BYPASS_EXIT1 16'h0090
`define FBM_BYPASS_EXIT2 16'h0000
`define FBM_SEQ_DEPTH 8
`define FBM_SEQ_AW 3

`endif

// *** src/fbm_pkg.sv ***
package fbm_pkg;
  // Host operations
  typedef enum logic [3:0] {
    FBM_OP_READ,
    FBM_OP_PROGRAM,
    FBM_OP_BYPASS_PROGRAM,
    FBM_OP_BYPASS_ENTER,
    FBM_OP_BYPASS_EXIT,
    FBM_OP_SECTOR_ERASE,
    FBM_OP_CHIP_ERASE,
    FBM_OP_ID_ENTER,
    FBM_OP_EXIT,
    FBM_OP_SUSPEND,
    FBM_OP_RESUME,
    FBM_OP_RESET
  } fbm_op_e;
  typedef logic [21:0] fbm_addr_t;
  typedef logic [15:0] fbm_data_t;
endpackage : fbm_pkg

// *** src/fbm_seq_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Write-cycle list between sequencer and its storage
interface fbm_seq_if;
  logic wr_en;
  logic [2:0] wr_idx;
  logic [37:0] wr_word;
  logic [2:0] rd_idx;
  logic [37:0] rd_word;
  modport owner (output wr_en, output wr_idx, output wr_word, output rd_idx, input rd_word);
  modport store (input wr_en, input wr_idx, input wr_word, input rd_idx, output rd_word);
endinterface : fbm_seq_if
`default_nettype wire

// *** src/fbm_seq_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Cycle list memory, registered read
// ----------------------------------------
module fbm_seq_mem (
  input wire logic clk_sys_in,
  fbm_seq_if.store seq
);
  logic [37:0] mem_q [0:7];
  logic [37:0] rd_q;

  // Store one address/data pair
  always_ff @(posedge clk_sys_in) begin
    if (seq.wr_en) begin
      mem_q[seq.wr_idx] <= seq.wr_word;
    end
  end

  // Registered read port
  always_ff @(posedge clk_sys_in) begin
    rd_q <= mem_q[seq.rd_idx];
  end

  assign seq.rd_word = rd_q;
endmodule : fbm_seq_mem
`default_nettype wire

// *** src/fbm_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fbm_defs.svh"
module fbm_host (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic req_valid_in,
  input wire fbm_pkg::fbm_op_e req_op_in,
  input wire logic [21:0] req_addr_in,
  input wire logic [15:0] req_data_in,
  input wire logic req_byte_mode_in,
  input wire logic req_accel_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [15:0] rsp_data_out,
  output logic busy_out,
  output logic [21:0] flash_addr_out,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe_n_out,
  input wire logic [15:0] flash_dq_in,
  output logic flash_select_n_out,
  output logic flash_gate_n_out,
  output logic flash_strobe_n_out,
  output logic width_select_out,
  output logic flash_reset_n_out,
  output logic protect_accel_pin_out,
  output logic accel_high_voltage_out,
  input wire logic ready_busy_n_in
);
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_WR, S_GAP, S_RD, S_RST, S_RWAIT, S_REC} fbm_st_e;
  fbm_st_e st_q;
  fbm_seq_if seq ();
  logic [`FBM_CNT_W-1:0] cnt_q;
  logic [2:0] idx_q;
  logic [2:0] len_q;
  logic ld_q;
  logic rb_m_q;
  logic rb_q;
  logic [15:0] dq_m_q;
  logic [15:0] dq_q;
  logic accel_q;

  // ----------------------------------------
  // Cycle list builder
  // ----------------------------------------
  function automatic logic [37:0] pack(input logic [21:0] a, input logic [15:0] d);
    pack = {a, d};
  endfunction

  // Word k of a command list for the given operation
  function automatic logic [37:0] cmd_word(input fbm_pkg::fbm_op_e op, input logic [2:0] k,
                                          input logic [21:0] a, input logic [15:0] d,
                                          input logic byp);
    logic [21:0] ba;
    ba = {a[21:20], 20'h00000};
    cmd_word = pack(`FBM_UNLOCK_A1, `FBM_UNLOCK_D1);
    if (k == 3'h1) begin
      cmd_word = pack(`FBM_UNLOCK_A2, `FBM_UNLOCK_D2);
    end
    case (op)
      fbm_pkg::FBM_OP_BYPASS_PROGRAM:
        cmd_word = (k == 3'h0) ? pack(a, `FBM_CMD_PROG) : pack(a, d);
      fbm_pkg::FBM_OP_PROGRAM:
        if (k == 3'h2) cmd_word = pack(`FBM_UNLOCK_A1, `FBM_CMD_PROG);
        else if (k == 3'h3) cmd_word = pack(a, d);
      fbm_pkg::FBM_OP_BYPASS_ENTER:
        if (k == 3'h2) cmd_word = pack(`FBM_UNLOCK_A1, `FBM_CMD_BYPASS);
      fbm_pkg::FBM_OP_BYPASS_EXIT:
        cmd_word = (k == 3'h0) ? pack(a, `FBM_BYPASS_EXIT1) : pack(a, `FBM_BYPASS_EXIT2);
      fbm_pkg::FBM_OP_SECTOR_ERASE, fbm_pkg::FBM_OP_CHIP_ERASE:
        if (k == 3'h2) cmd_word = pack(`FBM_UNLOCK_A1, `FBM_CMD_ERASE);
        else if (k == 3'h3) cmd_word = pack(`FBM_UNLOCK_A1, `FBM_UNLOCK_D1);
        else if (k == 3'h4) cmd_word = pack(`FBM_UNLOCK_A2, `FBM_UNLOCK_D2);
        else if (k == 3'h5) cmd_word = (op == fbm_pkg::FBM_OP_CHIP_ERASE) ?
                                       pack(`FBM_UNLOCK_A1, `FBM_CMD_CHIP) :
                                       pack(a, `FBM_CMD_SECT);
      // bank address on the upper bits
      fbm_pkg::FBM_OP_ID_ENTER:
        if (k == 3'h2) cmd_word = pack(ba | `FBM_UNLOCK_A1, `FBM_CMD_ID);
      fbm_pkg::FBM_OP_SUSPEND:
        cmd_word = pack(ba, `FBM_CMD_SUSPEND);
      fbm_pkg::FBM_OP_RESUME:
        cmd_word = pack(ba, `FBM_CMD_RESUME);
      fbm_pkg::FBM_OP_EXIT:
        cmd_word = pack(a, `FBM_CMD_EXIT);
      default: cmd_word = pack(a, d);
    endcase
    if (byp) begin
      cmd_word = cmd_word;
    end
  endfunction

  function automatic logic [2:0] cmd_len(input fbm_pkg::fbm_op_e op);
    case (op)
      fbm_pkg::FBM_OP_PROGRAM: cmd_len = 3'h4;
      fbm_pkg::FBM_OP_BYPASS_PROGRAM, fbm_pkg::FBM_OP_BYPASS_EXIT: cmd_len = 3'h2;
      fbm_pkg::FBM_OP_BYPASS_ENTER, fbm_pkg::FBM_OP_ID_ENTER: cmd_len = 3'h3;
      fbm_pkg::FBM_OP_SECTOR_ERASE, fbm_pkg::FBM_OP_CHIP_ERASE: cmd_len = 3'h6;
      default: cmd_len = 3'h1;
    endcase
  endfunction

  fbm_seq_mem u_mem (
    .clk_sys_in(clk_sys_in),
    .seq(seq)
  );

  // Load the list one word per cycle at request acceptance
  logic [2:0] fill_q;
  fbm_pkg::fbm_op_e op_q;
  logic [21:0] a_q;
  logic [15:0] d_q;
  assign seq.wr_en = (st_q == S_SETUP) && ld_q;
  assign seq.wr_idx = fill_q;
  assign seq.wr_word = cmd_word(op_q, fill_q, a_q, d_q, accel_q);
  assign seq.rd_idx = idx_q;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rb_m_q <= 1'b1;
      rb_q <= 1'b1;
      dq_m_q <= 16'h0000;
      dq_q <= 16'h0000;
    end else begin
      rb_m_q <= ready_busy_n_in;
      rb_q <= rb_m_q;
      dq_m_q <= flash_dq_in;
      dq_q <= dq_m_q;
    end
  end

  // ----------------------------------------
  // Bus sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= S_IDLE;
      cnt_q <= '0;
      idx_q <= 3'h0;
      len_q <= 3'h0;
      fill_q <= 3'h0;
      ld_q <= 1'b0;
      op_q <= fbm_pkg::FBM_OP_READ;
      a_q <= 22'h000000;
      d_q <= 16'h0000;
      req_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_data_out <= 16'h0000;
      flash_addr_out <= 22'h000000;
      flash_dq_out <= 16'h0000;
      flash_dq_oe_n_out <= 1'b1;
      flash_select_n_out <= 1'b1;
      flash_gate_n_out <= 1'b1;
      flash_strobe_n_out <= 1'b1;
      flash_reset_n_out <= 1'b0;
    end else begin
      rsp_valid_out <= 1'b0;
      req_ready_out <= 1'b0;
      case (st_q)
        S_IDLE: begin
          // idle bus: select high, reset high gives standby
          flash_select_n_out <= 1'b1;
          flash_gate_n_out <= 1'b1;
          flash_strobe_n_out <= 1'b1;
          flash_dq_oe_n_out <= 1'b1;
          flash_reset_n_out <= 1'b1;
          if (req_valid_in) begin
            req_ready_out <= 1'b1;
            op_q <= req_op_in;
            a_q <= req_addr_in;
            d_q <= req_data_in;
            cnt_q <= '0;
            if (req_op_in == fbm_pkg::FBM_OP_RESET) begin
              // hold reset low for the minimum pulse
              flash_reset_n_out <= 1'b0;
              st_q <= S_RST;
            end else if (req_op_in == fbm_pkg::FBM_OP_READ) begin
              // read: select and gate low, strobe high
              flash_addr_out <= req_addr_in;
              flash_select_n_out <= 1'b0;
              flash_gate_n_out <= 1'b0;
              st_q <= S_RD;
            end else begin
              len_q <= cmd_len(req_op_in);
              fill_q <= 3'h0;
              idx_q <= 3'h0;
              ld_q <= 1'b1;
              st_q <= S_SETUP;
            end
          end
        end
        S_SETUP: begin
          // Fill the list, then wait one cycle for the registered read
          if (ld_q) begin
            fill_q <= fill_q + 3'h1;
            if (fill_q + 3'h1 == len_q) begin
              ld_q <= 1'b0;
            end
          end else if (cnt_q == '0) begin
            // Let the last stored word reach the registered read port
            cnt_q <= cnt_q + 1'b1;
          end else begin
            flash_addr_out <= seq.rd_word[37:16];
            flash_dq_out <= seq.rd_word[15:0];
            flash_dq_oe_n_out <= 1'b0;
            flash_select_n_out <= 1'b0;
            cnt_q <= '0;
            st_q <= S_WR;
          end
        end
        S_WR: begin
          // write pulse with gate held high
          flash_gate_n_out <= 1'b1;
          flash_strobe_n_out <= 1'b0;
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == `FBM_CNT_W'(`FBM_WRITE_CYC)) begin
            flash_strobe_n_out <= 1'b1;
            idx_q <= idx_q + 3'h1;
            st_q <= S_GAP;
          end
        end
        S_GAP: begin
          flash_select_n_out <= 1'b1;
          if (idx_q == len_q) begin
            // deselect is safe: the device finishes on its own
            rsp_valid_out <= 1'b1;
            st_q <= S_IDLE;
          end else begin
            ld_q <= 1'b0;
            st_q <= S_SETUP;
          end
        end
        S_RD: begin
          // wait full access time from select and address
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == `FBM_CNT_W'(`FBM_ACCESS_CYC + 2)) begin
            // sample all sixteen lines, also in id mode
            rsp_data_out <= dq_q;
            rsp_valid_out <= 1'b1;
            flash_select_n_out <= 1'b1;
            flash_gate_n_out <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        S_RST: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == `FBM_CNT_W'(`FBM_RESET_CYC)) begin
            flash_reset_n_out <= 1'b1;
            cnt_q <= '0;
            st_q <= S_RWAIT;
          end
        end
        S_RWAIT: begin
          // wait for ready_busy_n high after reset
          cnt_q <= cnt_q + 1'b1;
          if (rb_q && cnt_q >= `FBM_CNT_W'(2)) begin
            cnt_q <= '0;
            st_q <= S_REC;
          end
        end
        S_REC: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == `FBM_CNT_W'(`FBM_RECOVERY_CYC)) begin
            rsp_valid_out <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Width and accelerate pins
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      width_select_out <= 1'b1;
      protect_accel_pin_out <= 1'b1;
      accel_high_voltage_out <= 1'b0;
      accel_q <= 1'b0;
      busy_out <= 1'b1;
    end else begin
      if (st_q == S_IDLE && req_valid_in) begin
        width_select_out <= ~req_byte_mode_in;
      end
      // high voltage only for bypass programming
      if (st_q == S_IDLE && req_valid_in) begin
        accel_q <= req_accel_in && (req_op_in == fbm_pkg::FBM_OP_BYPASS_PROGRAM);
      end else if (st_q == S_IDLE) begin
        accel_q <= 1'b0;
      end
      accel_high_voltage_out <= accel_q;
      protect_accel_pin_out <= 1'b1;
      // device busy raises busy_out whatever the bank; reads still allowed
      busy_out <= (st_q != S_IDLE) || !rb_q;
    end
  end
endmodule : fbm_host
`default_nettype wire

// *** tb/fbm_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fbm_defs.svh"
// ----------------------------------------
// Flash device model
// ----------------------------------------
module fbm_flash_model #(
  parameter logic [15:0] ID_CODE = 16'h5A3C // Arbitrary value
) (
  input wire logic clk_sys_in,
  input wire logic [21:0] addr_in,
  input wire logic [15:0] dq_in,
  input wire logic select_n_in,
  input wire logic gate_n_in,
  input wire logic strobe_n_in,
  input wire logic width_select_in,
  input wire logic reset_n_in,
  input wire logic accel_in,
  output logic [15:0] dq_out,
  output logic ready_busy_n_out,
  output logic [2:0] prog_cycles_out
);
  logic [15:0] mem [16];
  logic [5:0][15:0] h;
  logic [15:0] wd, dq_q, rd_w;
  logic [21:0] wa;
  logic [5:0] busy_cnt;
  logic [1:0] acc_cnt;
  logic id_q, byp_q, str_q, rd_ok;
  wire logic [3:0] ri = {addr_in[21:20], addr_in[13], addr_in[0]};
  wire logic [3:0] wi = {wa[21:20], wa[13], wa[0]};
  wire logic u1 = h[0] == `FBM_UNLOCK_D2 && h[1] == `FBM_UNLOCK_D1;
  wire logic u2 = h[1] == `FBM_UNLOCK_D2 && h[2] == `FBM_UNLOCK_D1;
  // Erased array and idle state at start
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
    {h, busy_cnt, acc_cnt, id_q, byp_q, dq_q, prog_cycles_out} = '0;
    str_q = 1'b1;
  end
  always @(posedge clk_sys_in) begin
    str_q <= strobe_n_in;
    dq_q <= dq_out;
    acc_cnt <= (select_n_in || gate_n_in) ? 2'h0 : acc_cnt + {1'b0, acc_cnt != 2'h3};
    if (busy_cnt != 6'h00) busy_cnt <= busy_cnt - 6'h01; // Runs on through reset
    if (!strobe_n_in && !select_n_in && gate_n_in) begin
      wd <= dq_in;
      wa <= addr_in;
    end
    if (!reset_n_in) begin
      {id_q, byp_q, h} <= '0;
    end else if (strobe_n_in && !str_q) begin
      h <= {h[4:0], wd};
      if (h[0] == `FBM_CMD_PROG && (byp_q || accel_in || u2)) begin
        if (width_select_in) mem[wi] <= wd;
        else mem[wi][7:0] <= wd[7:0];
        busy_cnt <= accel_in ? 6'h14 : 6'h28;
        prog_cycles_out <= u2 ? 3'h4 : 3'h2;
      end else if (u1 && h[2] == `FBM_CMD_ERASE && wd == `FBM_CMD_CHIP) begin
        for (int i = 0; i < 16; i++) mem[i] <= 16'hFFFF;
        busy_cnt <= 6'h3F;
      end else if (u1 && h[2] == `FBM_CMD_ERASE && wd == `FBM_CMD_SECT) begin
        mem[{wi[3:1], 1'b0}] <= 16'hFFFF;
        mem[{wi[3:1], 1'b1}] <= 16'hFFFF;
        busy_cnt <= 6'h3F;
      end else if (u1 && wd == `FBM_CMD_BYPASS) byp_q <= 1'b1;
      else if (u1 && wd == `FBM_CMD_ID) id_q <= 1'b1;
      else if (byp_q && h[0] == `FBM_BYPASS_EXIT1 && wd == `FBM_BYPASS_EXIT2) byp_q <= 1'b0;
      else if (wd == `FBM_CMD_EXIT) id_q <= 1'b0;
    end
  end
  // data after select access, else a wandering value
  assign rd_ok = !select_n_in && !gate_n_in && reset_n_in && acc_cnt == 2'h3;
  assign rd_w = id_q ? ID_CODE : mem[ri];
  assign dq_out = !rd_ok ? ~dq_q : width_select_in ? rd_w : {~dq_q[15:8], rd_w[7:0]};
  assign ready_busy_n_out = busy_cnt == 6'h00;
endmodule : fbm_flash_model
`default_nettype wire

// *** tb/fbm_host_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Pin protocol checker
// ----------------------------------------
module fbm_host_checker (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic busy_out,
  input wire logic flash_dq_oe_n_out,
  input wire logic flash_select_n_out,
  input wire logic flash_gate_n_out,
  input wire logic flash_strobe_n_out,
  input wire logic flash_reset_n_out,
  input wire logic protect_accel_pin_out,
  input wire logic ready_busy_n_in
);
  logic [9:0] rst_cnt_q;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  sequence gate_held_s; flash_gate_n_out [*2]; endsequence
  sequence access_wait_s; !flash_gate_n_out [*3]; endsequence
  // Length of the reset pulse driven to the device
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) rst_cnt_q <= 10'h014;
    else if (flash_reset_n_out) rst_cnt_q <= 10'h000;
    else if (rst_cnt_q != 10'h3FF) rst_cnt_q <= rst_cnt_q + 10'h001;
  end
  cmd_write_a: assert property (!flash_strobe_n_out |-> flash_gate_n_out && !flash_select_n_out)
    else $error("write strobe without select or with gate low");
  write_pulse_a: assert property ($fell(flash_strobe_n_out) |-> !flash_strobe_n_out [*2])
    else $error("write strobe pulse too short");
  array_read_a: assert property (!flash_gate_n_out |-> flash_strobe_n_out && !flash_select_n_out)
    else $error("output gate low without select or with strobe low");
  read_access_a: assert property ($fell(flash_gate_n_out) |-> access_wait_s)
    else $error("read ended before access time");
  reset_pulse_a: assert property ($rose(flash_reset_n_out) |-> rst_cnt_q >= 10'h014)
    else $error("device reset pulse too short");
  reset_quiet_a: assert property (!flash_reset_n_out |-> flash_dq_oe_n_out && flash_strobe_n_out && flash_gate_n_out)
    else $error("bus activity during device reset");
  reset_recover_a: assert property ($rose(flash_reset_n_out) |-> gate_held_s)
    else $error("read inside reset recovery");
  accel_pin_a: assert property (protect_accel_pin_out)
    else $error("protect pin not driven high");
  busy_seen_a: assert property (!ready_busy_n_in [*4] |-> busy_out)
    else $error("device busy not reported");
endmodule : fbm_host_checker
bind fbm_host fbm_host_checker u_chk (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
  .busy_out(busy_out), .flash_dq_oe_n_out(flash_dq_oe_n_out),
  .flash_select_n_out(flash_select_n_out), .flash_gate_n_out(flash_gate_n_out),
  .flash_strobe_n_out(flash_strobe_n_out), .flash_reset_n_out(flash_reset_n_out),
  .protect_accel_pin_out(protect_accel_pin_out), .ready_busy_n_in(ready_busy_n_in));
`default_nettype wire

// *** tb/fbm_host_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Testbench top
// ----------------------------------------
module fbm_host_test;
  logic clk_sys_in = 1'b0, reset_n_in = 1'b0, req_valid_in = 1'b0;
  logic req_byte_mode_in = 1'b0, req_accel_in = 1'b0, accel_seen = 1'b0;
  fbm_pkg::fbm_op_e req_op_in = fbm_pkg::FBM_OP_READ;
  logic [21:0] req_addr_in = 22'h000000;
  logic [15:0] req_data_in = 16'h0000;
  logic req_ready_out, rsp_valid_out, busy_out, dq_oe_n, sel_n, gate_n, strobe_n, wsel;
  logic frst_n, prot, accel_hv, rb_n;
  logic [21:0] faddr;
  logic [15:0] rsp_data_out, fdq_out, dev_dq, rd;
  logic [2:0] pcyc;
  wire logic [15:0] dq_wire = !dq_oe_n ? fdq_out : dev_dq;
  int num_errors = 0, n_checks = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  // Note any high-voltage request
  always @(posedge clk_sys_in) if (accel_hv === 1'b1) accel_seen <= 1'b1;
  fbm_host dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .req_valid_in(req_valid_in),
    .req_op_in(req_op_in), .req_addr_in(req_addr_in), .req_data_in(req_data_in),
    .req_byte_mode_in(req_byte_mode_in), .req_accel_in(req_accel_in),
    .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
    .busy_out(busy_out), .flash_addr_out(faddr), .flash_dq_out(fdq_out),
    .flash_dq_oe_n_out(dq_oe_n), .flash_dq_in(dq_wire), .flash_select_n_out(sel_n),
    .flash_gate_n_out(gate_n), .flash_strobe_n_out(strobe_n), .width_select_out(wsel),
    .flash_reset_n_out(frst_n), .protect_accel_pin_out(prot),
    .accel_high_voltage_out(accel_hv), .ready_busy_n_in(rb_n));
  fbm_flash_model u_dev (.clk_sys_in(clk_sys_in), .addr_in(faddr), .dq_in(dq_wire),
    .select_n_in(sel_n), .gate_n_in(gate_n), .strobe_n_in(strobe_n), .width_select_in(wsel),
    .reset_n_in(frst_n), .accel_in(accel_hv), .dq_out(dev_dq), .ready_busy_n_out(rb_n),
    .prog_cycles_out(pcyc));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // One request, its answer, then optionally the end of device busy
  task automatic op(input fbm_pkg::fbm_op_e o, input logic [21:0] a, input logic [15:0] d,
                    input logic bm, input logic acc, input logic wt);
    int n;
    @(posedge clk_sys_in);
    req_op_in <= o;
    req_addr_in <= a;
    req_data_in <= d;
    req_byte_mode_in <= bm;
    req_accel_in <= acc;
    req_valid_in <= 1'b1;
    n = 0;
    while (req_ready_out !== 1'b1 && n < 3000) begin @(negedge clk_sys_in); n++; end
    @(posedge clk_sys_in) req_valid_in <= 1'b0;
    while (rsp_valid_out !== 1'b1 && n < 6000) begin @(negedge clk_sys_in); n++; end
    rd = rsp_data_out;
    while (wt && busy_out !== 1'b0 && n < 9000) begin @(negedge clk_sys_in); n++; end
    if (n >= 3000) num_errors++;
  endtask : op
  task automatic t_after_reset();
    op(fbm_pkg::FBM_OP_READ, 22'h000010, 16'h0000, 1'b0, 1'b0, 1'b1);
    check(rd, 16'hFFFF);
  endtask : t_after_reset
  task automatic t_program();
    op(fbm_pkg::FBM_OP_PROGRAM, 22'h100004, 16'hA5C3, 1'b0, 1'b0, 1'b1);
    check({13'h0000, pcyc}, 16'h0004);
    check({15'h0000, accel_seen}, 16'h0000);
    op(fbm_pkg::FBM_OP_READ, 22'h100004, 16'h0000, 1'b0, 1'b0, 1'b1);
    check(rd, 16'hA5C3);
    op(fbm_pkg::FBM_OP_PROGRAM, 22'h200008, 16'h005A, 1'b1, 1'b0, 1'b1);
    check({15'h0000, wsel}, 16'h0000);
    op(fbm_pkg::FBM_OP_READ, 22'h200008, 16'h0000, 1'b1, 1'b0, 1'b1);
    check({8'h00, rd[7:0]}, 16'h005A);
  endtask : t_program
  task automatic t_bypass();
    op(fbm_pkg::FBM_OP_BYPASS_ENTER, 22'h300000, 16'h0000, 1'b0, 1'b0, 1'b1);
    op(fbm_pkg::FBM_OP_BYPASS_PROGRAM, 22'h300002, 16'h1357, 1'b0, 1'b0, 1'b1);
    check({13'h0000, pcyc}, 16'h0002);
    op(fbm_pkg::FBM_OP_BYPASS_PROGRAM, 22'h300003, 16'h2468, 1'b0, 1'b1, 1'b1);
    check({15'h0000, accel_seen}, 16'h0001);
    check({15'h0000, accel_hv}, 16'h0000);
    op(fbm_pkg::FBM_OP_BYPASS_EXIT, 22'h300000, 16'h0000, 1'b0, 1'b0, 1'b1);
    op(fbm_pkg::FBM_OP_READ, 22'h300003, 16'h0000, 1'b0, 1'b0, 1'b1);
    check(rd, 16'h2468);
  endtask : t_bypass
  // identification codes, then back to array
  task automatic t_ident();
    op(fbm_pkg::FBM_OP_ID_ENTER, 22'h000000, 16'h0000, 1'b0, 1'b0, 1'b1);
    op(fbm_pkg::FBM_OP_READ, 22'h000000, 16'h0000, 1'b0, 1'b0, 1'b1);
    check(rd, 16'h5A3C);
    op(fbm_pkg::FBM_OP_EXIT, 22'h000000, 16'h0000, 1'b0, 1'b0, 1'b1);
    op(fbm_pkg::FBM_OP_READ, 22'h100004, 16'h0000, 1'b0, 1'b0, 1'b1);
    check(rd, 16'hA5C3);
  endtask : t_ident
  // sector erase leaves other banks, chip erase clears all
  task automatic t_erase();
    op(fbm_pkg::FBM_OP_SECTOR_ERASE, 22'h100004, 16'h0000, 1'b0, 1'b0, 1'b1);
    op(fbm_pkg::FBM_OP_READ, 22'h100004, 16'h0000, 1'b0, 1'b0, 1'b1);
    check(rd, 16'hFFFF);
    op(fbm_pkg::FBM_OP_READ, 22'h300002, 16'h0000, 1'b0, 1'b0, 1'b1);
    check(rd, 16'h1357);
    op(fbm_pkg::FBM_OP_CHIP_ERASE, 22'h000000, 16'h0000, 1'b0, 1'b0, 1'b1);
    op(fbm_pkg::FBM_OP_READ, 22'h300002, 16'h0000, 1'b0, 1'b0, 1'b1);
    check(rd, 16'hFFFF);
  endtask : t_erase
  // read during suspended erase in the same bank
  task automatic t_suspend();
    op(fbm_pkg::FBM_OP_PROGRAM, 22'h000001, 16'h0F0F, 1'b0, 1'b0, 1'b1);
    op(fbm_pkg::FBM_OP_SECTOR_ERASE, 22'h002000, 16'h0000, 1'b0, 1'b0, 1'b0);
    op(fbm_pkg::FBM_OP_SUSPEND, 22'h002000, 16'h0000, 1'b0, 1'b0, 1'b0);
    op(fbm_pkg::FBM_OP_READ, 22'h000001, 16'h0000, 1'b0, 1'b0, 1'b0);
    check(rd, 16'h0F0F);
    op(fbm_pkg::FBM_OP_RESUME, 22'h002000, 16'h0000, 1'b0, 1'b0, 1'b1);
  endtask : t_suspend
  // reset while busy and while idle
  task automatic t_reset();
    op(fbm_pkg::FBM_OP_PROGRAM, 22'h200010, 16'h1111, 1'b0, 1'b0, 1'b0);
    op(fbm_pkg::FBM_OP_RESET, 22'h000000, 16'h0000, 1'b0, 1'b0, 1'b0);
    check({15'h0000, rb_n}, 16'h0001);
    op(fbm_pkg::FBM_OP_RESET, 22'h000000, 16'h0000, 1'b0, 1'b0, 1'b1);
    op(fbm_pkg::FBM_OP_READ, 22'h000001, 16'h0000, 1'b0, 1'b0, 1'b1);
    check(rd, 16'h0F0F);
  endtask : t_reset
  // Watchdog
  initial begin
    #1500000;
    num_errors++;
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    t_after_reset();
    t_program();
    t_bypass();
    t_ident();
    t_erase();
    t_suspend();
    t_reset();
    end_of_test();
  end
endmodule : fbm_host_test
`default_nettype wire
